// ### src/ctp_pkg.sv
// constants for the compat timer pwm unit: register map, fields, timing
// assumes a 50 MHz pclk and an apb master with 32-bit data
// Summary of operation
// - control and compare reads return last write
// - count and flag reads lag by synchronisation
// - written values other than the mask pass a sync stage first
// - normal mode: duty compare or a forced compare drives output
// - duty match drives pin and compare flag
// - wrap flag on ff to 0, or top
// - pwm: count zero to top, restart
// - pwm modes: 00 off, 01 off except with duty at zero or top, 10 clear, 11 set
// - pwm top match sets wrap flag, delayed
// - pwm duty writes buffered until top reached
// - duty read returns buffered value
// - duty at zero or top holds output
// - irq needs flag, enable and global enable
// - pwm period is top plus one ticks
// - high time duty ticks in clear mode, top plus one minus duty in set mode
// - fast 25.6 MHz clock drives prescaler
// - clear on match resets count after match
// - pwm enable selects pwm mode
// - flags cleared by vector or writing one
package ctp_pkg;
  // byte offsets of the registers
  localparam logic [31:0] OFS_TIMER_CTRL = 32'h0000_0000;
  localparam logic [31:0] OFS_GEN_CTRL   = 32'h0000_0004;
  localparam logic [31:0] OFS_COUNT      = 32'h0000_0008;
  localparam logic [31:0] OFS_DUTY       = 32'h0000_000c;
  localparam logic [31:0] OFS_TOP        = 32'h0000_0010;
  localparam logic [31:0] OFS_MASK       = 32'h0000_0014;
  localparam logic [31:0] OFS_FLAG       = 32'h0000_0018;
  // timer_control fields
  localparam int BIT_CLEAR_ON_MATCH = 7;
  localparam int BIT_PWM_ENABLE     = 6;
  localparam int BIT_OUT_MODE_HI    = 5;
  localparam int BIT_OUT_MODE_LO    = 4;
  // general_timer_control fields, both read as zero
  localparam int BIT_FORCE_CMP      = 2;
  localparam int BIT_PRESC_CLEAR    = 1;
  // mask and flag fields share positions
  localparam int BIT_CMP            = 6;
  localparam int BIT_WRAP           = 2;
  // reset value and counter maximum
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hff;
  // output modes
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_TOGGLE = 2'h1;
  localparam logic [1:0] MODE_CLEAR  = 2'h2;
  localparam logic [1:0] MODE_SET    = 2'h3;
  // clock select codes
  localparam logic [3:0] CS_STOP     = 4'h0;
  localparam logic [3:0] CS_FAST1    = 4'h1;
  localparam logic [3:0] CS_FAST8    = 4'h4;
  localparam logic [3:0] CS_SYS1     = 4'h5;
  // clock rates and the fractional fast clock divider
  localparam int PCLK_HZ         = 50_000_000;
  localparam int FAST_HZ         = 25_600_000;
  localparam int FAST_PERIOD_PS  = 39_100;
  localparam int RATIO_STEP_HZ   = 400_000;
  localparam int FAST_NUM        = FAST_HZ / RATIO_STEP_HZ;
  localparam int FAST_DEN        = PCLK_HZ / RATIO_STEP_HZ;
endpackage

// ### src/ctp_tick_if.sv
// carrier between the timer core and its prescaler
// assumes both ends run on pclk
`timescale 1ns/1ps
interface ctp_tick_if;
  logic [3:0] clock_select; // synced clock select code
  logic       presc_clear;  // one-cycle prescaler reset
  logic       tick;         // one-cycle timer_clock enable
  modport core (output clock_select, output presc_clear, input tick);
  modport gen  (input clock_select, input presc_clear, output tick);
endinterface

// ### src/ctp_prescaler.sv
// prescaler: fast clock enable plus fast and system dividers
// assumes pclk is the system clock and one clock domain
`timescale 1ns/1ps
module ctp_prescaler
  import ctp_pkg::*;
#(
  parameter int NUM = FAST_NUM,
  parameter int DEN = FAST_DEN
) (
  input  wire logic pclk,
  input  wire logic presetn,
  ctp_tick_if.gen   tk
);
  // the accumulator can only serve a ratio below one; refused at
  // elaboration so a bad override never reaches simulation
  if (NUM < 1 || NUM >= DEN || DEN > 255) begin
    $error("ctp_prescaler: fast ratio out of range");
  end

  localparam logic [7:0] NUM_B = 8'(NUM);
  localparam logic [7:0] DEN_B = 8'(DEN);

  logic [7:0] acc_q, acc_d;     // phase accumulator
  logic       fen_q, fen_d;     // fast clock enable
  logic [2:0] fdiv_q, fdiv_d;   // fast divider
  logic [9:0] sdiv_q, sdiv_d;   // system divider
  logic       tick_q, tick_d;   // selected tick
  logic [3:0] k;                // divider exponent

  // next values: fractional enable and both dividers
  always_comb begin
    acc_d  = acc_q + NUM_B;
    fen_d  = 1'b0;
    fdiv_d = fdiv_q;
    sdiv_d = sdiv_q + 10'h001;
    // fast clock as an enable at 25.6 MHz on average
    if (acc_q + NUM_B >= DEN_B) begin
      acc_d = acc_q + NUM_B - DEN_B;
      fen_d = 1'b1;
    end
    if (fen_q) begin
      fdiv_d = fdiv_q + 3'h1;
    end
    // prescaler reset leaves the counter alone
    if (tk.presc_clear) begin
      fdiv_d = 3'h0;
      sdiv_d = 10'h000;
    end
    // tick select: fast codes use fen, others the system divider
    tick_d = 1'b0;
    k      = 4'h0;
    if (tk.clock_select == CS_STOP) begin
      tick_d = 1'b0;
    end else if (tk.clock_select <= CS_FAST8) begin
      k      = tk.clock_select - CS_FAST1;
      tick_d = fen_q && ((fdiv_q & 3'((4'h1 << k) - 4'h1)) ==
                         3'((4'h1 << k) - 4'h1));
    end else begin
      k      = tk.clock_select - CS_SYS1;
      tick_d = ((sdiv_q & 10'((11'h001 << k) - 11'h001)) ==
                10'((11'h001 << k) - 11'h001));
    end
  end

  // register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q  <= 8'h00;
      fen_q  <= 1'b0;
      fdiv_q <= 3'h0;
      sdiv_q <= 10'h000;
      tick_q <= 1'b0;
    end else begin
      acc_q  <= acc_d;
      fen_q  <= fen_d;
      fdiv_q <= fdiv_d;
      sdiv_q <= sdiv_d;
      tick_q <= tick_d;
    end
  end

  assign tk.tick = tick_q;
endmodule

// ### src/ctp_timer_top.sv
// timer core: apb registers, counter, compare, flags and pin
// assumes an apb master on pclk and a core that gives global enable
`timescale 1ns/1ps
module ctp_timer_top
  import ctp_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        global_irq_en,
  input  wire logic        vec_ack_compare,
  input  wire logic        vec_ack_wrap,
  output logic             irq_compare,
  output logic             irq_wrap,
  output logic             compare_out_pin,
  output logic             compare_out_en
);
  // the datapath is built for byte-wide registers only; other widths
  // are refused while elaborating rather than at time zero
  if (CNT_W != 8) begin
    $error("ctp_timer_top: only an 8 bit counter is supported");
  end

  ctp_tick_if tk ();

  ctp_prescaler u_presc (
    .pclk    (pclk),
    .presetn (presetn),
    .tk      (tk)
  );

  // bus side
  logic [31:0] prdata_q, prdata_d;   // read data
  logic        pready_q, pready_d;   // access phase ready
  logic        pslverr_q, pslverr_d; // unmapped answer
  logic        setup;                // setup cycle seen
  logic        wr;                   // write completes now
  logic        mapped;               // address hits a register
  logic [31:0] rmux;                 // read value

  // software visible state
  logic [7:0] ctl_q, ctl_d;          // timer_control
  logic [7:0] mask_q, mask_d;        // timer_mask_reg
  logic [7:0] top_q, top_d;          // top_compare
  logic [7:0] dbuf_q, dbuf_d;        // duty_compare holding buffer
  logic       cwr_q, cwr_d;          // count write pending
  logic [7:0] cval_q, cval_d;        // count write value
  logic       force_q, force_d;      // force compare pending
  logic       pclr_q, pclr_d;        // prescaler clear pulse
  logic [1:0] fclr_q, fclr_d;        // flag clear pending, cmp/wrap

  // synced copies seen by the counter
  logic [7:0] ctl_s_q;               // control after sync
  logic [7:0] top_s_q;               // top after sync

  // counter side
  logic [7:0] cnt_q, cnt_d;          // count_value
  logic       adv_q, adv_d;          // counter advanced last cycle
  logic [7:0] duty_q, duty_d;        // active duty compare
  logic       wev_q, wev_d;          // wrap event stage
  logic       cev_q, cev_d;          // compare event stage
  logic       cflag_q, cflag_d;      // compare_match_flag
  logic       wflag_q, wflag_d;      // wrap_flag
  logic [7:0] cnt_rb_q;              // count readback copy
  logic [1:0] flag_rb_q;             // flag readback copy
  logic       out_q, out_d;          // pin level
  logic       oe_q, oe_d;            // pin enable
  logic       irqc_q, irqc_d;        // compare request
  logic       irqw_q, irqw_d;        // wrap request

  logic       pwm;                   // pwm_enable, synced
  logic       ctc;                   // clear_on_match, synced
  logic [1:0] mode;                  // out_mode_hi/lo, synced
  logic       match_a;               // counter reached duty

  assign pwm  = ctl_s_q[BIT_PWM_ENABLE];
  assign ctc  = ctl_s_q[BIT_CLEAR_ON_MATCH];
  assign mode = ctl_s_q[BIT_OUT_MODE_HI:BIT_OUT_MODE_LO];
  // only a count reached by counting is a match
  assign match_a = adv_q && (cnt_q == duty_q);

  // apb decode, read mux and write strobes
  always_comb begin
    setup  = psel && !penable;
    wr     = psel && penable && pready_q && pwrite && pstrb[0];
    mapped = (paddr[1:0] == 2'h0) && (paddr <= OFS_FLAG);
    rmux   = 32'h0000_0000;
    unique case (paddr)
      OFS_TIMER_CTRL: rmux = {24'h00_0000, ctl_q};
      OFS_DUTY:       rmux = {24'h00_0000, dbuf_q};
      OFS_TOP:        rmux = {24'h00_0000, top_q};
      OFS_COUNT:      rmux = {24'h00_0000, cnt_rb_q};
      OFS_MASK: begin
        rmux[BIT_CMP]  = mask_q[BIT_CMP];
        rmux[BIT_WRAP] = mask_q[BIT_WRAP];
      end
      OFS_FLAG: begin
        rmux[BIT_CMP]  = flag_rb_q[1];
        rmux[BIT_WRAP] = flag_rb_q[0];
      end
      default: rmux = 32'h0000_0000; // gen ctrl reads zero
    endcase
    pready_d  = setup;
    pslverr_d = setup && !mapped;
    prdata_d  = setup ? (pwrite ? 32'h0000_0000 : rmux) : prdata_q;
  end

  // software register next values
  always_comb begin
    ctl_d   = ctl_q;
    mask_d  = mask_q;
    top_d   = top_q;
    dbuf_d  = dbuf_q;
    cwr_d   = 1'b0;
    cval_d  = cval_q;
    force_d = 1'b0;
    pclr_d  = 1'b0;
    fclr_d  = 2'h0;
    if (wr) begin
      unique case (paddr)
        OFS_TIMER_CTRL: ctl_d = pwdata[7:0];
        OFS_TOP:        top_d = pwdata[7:0];
        OFS_DUTY:       dbuf_d = pwdata[7:0];
        OFS_MASK: begin
          mask_d[BIT_CMP]  = pwdata[BIT_CMP];
          mask_d[BIT_WRAP] = pwdata[BIT_WRAP];
        end
        OFS_COUNT: begin
          cwr_d  = 1'b1;
          cval_d = pwdata[7:0];
        end
        OFS_GEN_CTRL: begin
          force_d = pwdata[BIT_FORCE_CMP];
          pclr_d  = pwdata[BIT_PRESC_CLEAR];
        end
        OFS_FLAG: begin
          fclr_d = {pwdata[BIT_CMP], pwdata[BIT_WRAP]};
        end
        default: ctl_d = ctl_q;
      endcase
    end
  end

  // counter, compare events, flags and requests
  always_comb begin
    cnt_d  = cnt_q;
    adv_d  = 1'b0;
    wev_d  = 1'b0;
    duty_d = duty_q;
    if (cwr_q) begin
      // software write wins over a tick and is no match
      cnt_d = cval_q;
    end else if (tk.tick) begin
      adv_d = 1'b1;
      wev_d = (cnt_q == CNT_MAX) ||
              (pwm && cnt_q == top_s_q);
      if (pwm && cnt_q == top_s_q) begin
        cnt_d = RST_BYTE;
      end else if (!pwm && ctc && cnt_q == duty_q) begin
        cnt_d = RST_BYTE;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
    // duty follows its buffer, in pwm only at top
    if (!pwm) begin
      duty_d = dbuf_q;
    end else if (tk.tick && cnt_q == top_s_q) begin
      duty_d = dbuf_q;
    end
    cev_d = match_a;
    // set wins over any clear in the same cycle
    cflag_d = cev_q ||
              (cflag_q && !(fclr_q[1] || vec_ack_compare));
    wflag_d = wev_q ||
              (wflag_q && !(fclr_q[0] || vec_ack_wrap));
    irqc_d  = cflag_q && mask_q[BIT_CMP] && global_irq_en;
    irqw_d  = wflag_q && mask_q[BIT_WRAP] && global_irq_en;
  end

  // compare output pin
  always_comb begin
    out_d = out_q;
    oe_d  = oe_q;
    if (!pwm) begin
      // normal mode, duty compare or a forced match
      oe_d = (mode != MODE_OFF);
      if (match_a || force_q) begin
        unique case (mode)
          MODE_TOGGLE: out_d = !out_q;
          MODE_CLEAR:  out_d = 1'b0;
          MODE_SET:    out_d = 1'b1;
          MODE_OFF:    out_d = out_q;
        endcase
      end
    end else if (duty_q == RST_BYTE) begin
      oe_d  = (mode != MODE_OFF);
      out_d = (mode == MODE_SET);
    end else if (duty_q == top_s_q) begin
      oe_d  = (mode != MODE_OFF);
      out_d = (mode != MODE_SET);
    end else begin
      oe_d = mode[1];
      // edges at zero and at duty give top+1 period, duty high in clear mode
      if (adv_q && cnt_q == RST_BYTE) begin
        out_d = (mode == MODE_CLEAR);
      end
      if (match_a) begin
        out_d = (mode == MODE_SET);
      end
    end
  end

  // register stage for bus and software state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      ctl_q     <= RST_BYTE;
      mask_q    <= RST_BYTE;
      top_q     <= RST_BYTE;
      dbuf_q    <= RST_BYTE;
      cwr_q     <= 1'b0;
      cval_q    <= RST_BYTE;
      force_q   <= 1'b0;
      pclr_q    <= 1'b0;
      fclr_q    <= 2'h0;
      ctl_s_q   <= RST_BYTE;
      top_s_q   <= RST_BYTE;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      ctl_q     <= ctl_d;
      mask_q    <= mask_d;
      top_q     <= top_d;
      dbuf_q    <= dbuf_d;
      cwr_q     <= cwr_d;
      cval_q    <= cval_d;
      force_q   <= force_d;
      pclr_q    <= pclr_d;
      fclr_q    <= fclr_d;
      ctl_s_q   <= ctl_q;
      top_s_q   <= top_q;
    end
  end

  // register stage for the counter side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q     <= RST_BYTE;
      adv_q     <= 1'b0;
      duty_q    <= RST_BYTE;
      wev_q     <= 1'b0;
      cev_q     <= 1'b0;
      cflag_q   <= 1'b0;
      wflag_q   <= 1'b0;
      cnt_rb_q  <= RST_BYTE;
      flag_rb_q <= 2'h0;
      out_q     <= 1'b0;
      oe_q      <= 1'b0;
      irqc_q    <= 1'b0;
      irqw_q    <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      adv_q     <= adv_d;
      duty_q    <= duty_d;
      wev_q     <= wev_d;
      cev_q     <= cev_d;
      cflag_q   <= cflag_d;
      wflag_q   <= wflag_d;
      cnt_rb_q  <= cnt_q;
      flag_rb_q <= {cflag_q, wflag_q};
      out_q     <= out_d;
      oe_q      <= oe_d;
      irqc_q    <= irqc_d;
      irqw_q    <= irqw_d;
    end
  end

  assign tk.clock_select = ctl_s_q[3:0];
  assign tk.presc_clear  = pclr_q;

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign irq_compare     = irqc_q;
  assign irq_wrap        = irqw_q;
  assign compare_out_pin = out_q;
  assign compare_out_en  = oe_q;
endmodule

// ### verification/ctp_timer_top_assertions.sv
// checker for the timer top: apb answer, interrupts, pin enable
// assumes one pclk domain and a bind onto ctp_timer_top
`timescale 1ns/1ps
module ctp_timer_chk
  import ctp_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        global_irq_en,
  input wire logic        vec_ack_compare,
  input wire logic        vec_ack_wrap,
  input wire logic        irq_compare,
  input wire logic        irq_wrap,
  input wire logic        compare_out_pin,
  input wire logic        compare_out_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] ctrl_q, ctrl_d; // last written timer_control
  logic [1:0] age_q, age_d;   // edges since that write
  logic       done;           // a transfer completes
  assign done = psel && penable && pready;
  // track control writes so pin settings can be judged
  always_comb begin
    ctrl_d = ctrl_q;
    age_d  = (age_q == 2'd3) ? age_q : age_q + 2'd1;
    if (done && pwrite && pstrb[0] && paddr == OFS_TIMER_CTRL) begin
      ctrl_d = pwdata[7:0];
      age_d  = 2'd0;
    end
  end
  // register the tracked control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= RST_BYTE;
      age_q  <= 2'd0;
    end else begin
      ctrl_q <= ctrl_d;
      age_q  <= age_d;
    end
  end
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_ctrl_readback: assert property (done && !pwrite &&
    paddr == OFS_TIMER_CTRL |-> prdata[7:0] == ctrl_q)
    else $error("control readback differs");
  a_byte_wide: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_wrap_irq_gate: assert property (irq_wrap |-> $past(global_irq_en))
    else $error("wrap irq without global enable");
  a_cmp_irq_gate: assert property (irq_compare |-> $past(global_irq_en))
    else $error("compare irq without global enable");
  a_ack_clears: assert property (vec_ack_wrap |-> ##2 !irq_wrap)
    else $error("wrap irq survives ack");
  a_off_released: assert property (age_q == 2'd3 &&
    ctrl_q[5:4] == MODE_OFF |-> !compare_out_en)
    else $error("pin driven in off mode");
  a_pwm_driven: assert property (age_q == 2'd3 &&
    ctrl_q[BIT_PWM_ENABLE] && ctrl_q[BIT_OUT_MODE_HI] |-> compare_out_en)
    else $error("pwm pin not driven");
  c_wrap_irq: cover property (irq_wrap);
  c_refused: cover property (pslverr);
  c_pwm_high: cover property (ctrl_q[6] && compare_out_en && compare_out_pin);
endmodule
bind ctp_timer_top ctp_timer_chk #(.CNT_W(CNT_W)) u_chk (.*);

// ### verification/ctp_load_model.sv
// load on the compare pin: measures period and high time
// assumes the pin is released when its enable is low
`timescale 1ns/1ps
module ctp_load_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pin,
  input  wire logic        en,
  output logic             level,
  output logic      [15:0] per,
  output logic      [15:0] hi
);
  logic        last_q; // last driven level
  logic        lvl_q;  // level one cycle ago
  logic [15:0] cnt;    // cycles since last rise
  logic [15:0] hcnt;   // high cycles since last rise
  // released wire shows the inverse of the last driven value
  assign level = en ? pin : ~last_q;
  // period and high time between rising edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {last_q, lvl_q, cnt, hcnt, per, hi} <= '0;
    end else begin
      if (en) last_q <= pin;
      lvl_q <= level;
      cnt   <= cnt + 16'd1;
      hcnt  <= hcnt + {15'd0, level};
      if (level && !lvl_q) begin
        per  <= cnt;
        hi   <= hcnt;
        cnt  <= 16'd1;
        hcnt <= 16'd1;
      end
    end
  end
endmodule

// ### verification/ctp_timer_top_bench.sv
// bench for the timer top: apb tasks and directed tests
// assumes the load model and the bound checker are compiled
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin \
  num_errors++; $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module compat_timer_pwm_unit_bench;
  import ctp_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata;
  logic [3:0]  pstrb = '0;
  logic pready, pslverr, gie = 0, ack_c = 0, ack_w = 0;
  logic irq_c, irq_w, pin, pin_en, level;
  logic [15:0] per, hi;
  int num_errors = 0, total_checks = 0, cyc = 0;
  logic [31:0] r;  // read data
  logic        e;  // error answer
  logic [15:0] hc; // high time in clear mode
  int n;
  logic        t0; // pin level before a forced compare
  always #10 pclk = ~pclk;
  ctp_timer_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_irq_en(gie), .vec_ack_compare(ack_c), .vec_ack_wrap(ack_w),
    .irq_compare(irq_c), .irq_wrap(irq_w), .compare_out_pin(pin),
    .compare_out_en(pin_en));
  ctp_load_model u_load (.pclk(pclk), .presetn(presetn), .pin(pin),
    .en(pin_en), .level(level), .per(per), .hi(hi));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    pstrb <= 4'h1;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1); // a wait that never sees pready is ended only by the hang guard
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [7:0] x);
    apb(0, a, '0);
    `CHK($sformatf("reg %h", a), {24'h0, x}, r)
  endtask
  task automatic level_run(input logic x); // count high cycles
    n = 0;
    repeat (20) begin
      @(posedge pclk);
      if (level === 1'b1) n++;
    end
    `CHK("held level", x ? 20 : 0, n)
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    for (int a = 0; a <= 'h18; a += 4) rd_chk(a, RST_BYTE);
    apb(0, 'h1c, '0);
    `CHK("unmapped err", 1'b1, e)
    apb(0, 'h02, '0);
    `CHK("misaligned err", 1'b1, e)
    $display("test reset done");
    apb(1, OFS_TOP, 'h5a);
    apb(1, OFS_DUTY, 'ha5);
    apb(1, OFS_TIMER_CTRL, 'h30);
    rd_chk(OFS_TOP, 8'h5a);
    rd_chk(OFS_DUTY, 8'ha5);
    rd_chk(OFS_TIMER_CTRL, 8'h30);
    $display("test readback done");
    // normal mode: wrap at ff, match at duty sets pin
    apb(1, OFS_MASK, 'h44);
    apb(1, OFS_DUTY, 'h20);
    apb(1, OFS_COUNT, 'hf8);
    apb(1, OFS_TIMER_CTRL, {24'h0, 4'h3, CS_SYS1});
    repeat (60) @(posedge pclk);
    rd_chk(OFS_FLAG, 8'h44);
    `CHK("irq off", 2'b00, {irq_c, irq_w})
    `CHK("pin set", 2'b11, {pin_en, pin})
    gie <= 1;
    repeat (3) @(posedge pclk);
    `CHK("irq on", 2'b11, {irq_c, irq_w})
    ack_w <= 1;
    @(posedge pclk);
    ack_w <= 0;
    repeat (3) @(posedge pclk);
    `CHK("wrap acked", 1'b0, irq_w)
    apb(1, OFS_FLAG, 'h40);
    repeat (4) @(posedge pclk);
    `CHK("cmp cleared", 1'b0, irq_c)
    gie <= 0;
    $display("test normal done");
    apb(1, OFS_TIMER_CTRL, {24'h0, 4'h8, CS_SYS1});
    apb(1, OFS_COUNT, 'h10); // start below the duty value
    repeat (2) @(posedge pclk);
    repeat (8) begin
      apb(0, OFS_COUNT, '0);
      `CHK("ctc bound", 1'b1, r[7:0] <= 8'h20)
    end
    rd_chk(OFS_FLAG, 8'h40);
    $display("test clear on match done");
    // pwm: period top plus one, clear and set complement
    apb(1, OFS_TIMER_CTRL, '0);
    apb(1, OFS_COUNT, '0);
    apb(1, OFS_TOP, 'd9);
    apb(1, OFS_DUTY, 'd3);
    apb(1, OFS_TIMER_CTRL, {24'h0, 4'h6, CS_SYS1});
    repeat (40) @(posedge pclk);
    `CHK("period", 16'd10, per)
    `CHK("high time", 1'b1, hi == 16'd4 || hi == 16'd3)
    apb(1, OFS_FLAG, 'h44);
    repeat (12) @(posedge pclk);
    rd_chk(OFS_FLAG, 8'h44);
    hc = hi;
    apb(1, OFS_TIMER_CTRL, {24'h0, 4'h7, CS_SYS1});
    repeat (40) @(posedge pclk);
    `CHK("set complement", 16'd10, hi + hc)
    $display("test pwm done");
    apb(1, OFS_TIMER_CTRL, {24'h0, 4'h6, CS_SYS1});
    apb(1, OFS_DUTY, 'd0);
    rd_chk(OFS_DUTY, 8'h00);
    repeat (30) @(posedge pclk);
    level_run(0);
    apb(1, OFS_TIMER_CTRL, {24'h0, 4'h6, CS_STOP});
    apb(1, OFS_DUTY, 'd9);
    rd_chk(OFS_DUTY, 8'h09);
    level_run(0);
    apb(1, OFS_TIMER_CTRL, {24'h0, 4'h6, CS_SYS1});
    repeat (30) @(posedge pclk);
    level_run(1);
    apb(1, OFS_TIMER_CTRL, {24'h0, 4'h7, CS_SYS1});
    repeat (10) @(posedge pclk);
    level_run(0);
    $display("test held levels done");
    // fast clock ticks on 64 of every 125 pclk cycles
    apb(1, OFS_TIMER_CTRL, '0);
    apb(1, OFS_COUNT, '0);
    apb(1, OFS_TIMER_CTRL, {24'h0, 4'h0, CS_FAST1});
    repeat (FAST_DEN) @(posedge pclk);
    apb(0, OFS_COUNT, '0);
    `CHK("fast ticks", 1'b1, r[7:0] >= 8'h3c && r[7:0] <= 8'h41)
    $display("test fast clock done");
    // normal toggle mode with a forced compare, clock stopped
    apb(1, OFS_TIMER_CTRL, {24'h0, 4'h1, CS_STOP});
    repeat (3) @(posedge pclk);
    t0 = pin;
    apb(1, OFS_GEN_CTRL, 'h4);
    repeat (3) @(posedge pclk);
    `CHK("forced toggle", {1'b1, ~t0}, {pin_en, pin})
    $display("test force done");
    tally_and_finish();
  end
endmodule
